// *** core/oag_pkg.sv ***
package oag_pkg;
    // operand modes presented by the decoder
    typedef enum logic [3:0] {
        OAG_M_NONE = 4'h0,
        OAG_M_REG8 = 4'h1,
        OAG_M_REG16 = 4'h2,
        OAG_M_IMM8 = 4'h3,
        OAG_M_IMM16 = 4'h4,
        OAG_M_SADDR = 4'h5,
        OAG_M_SADDRP = 4'h6,
        OAG_M_SFR = 4'h7,
        OAG_M_SFRP = 4'h8,
        OAG_M_IND8 = 4'h9,
        OAG_M_INDHL = 4'ha,
        OAG_M_INDEX = 4'hb,
        OAG_M_IDXREG = 4'hc,
        OAG_M_LOOPREG = 4'hd
    } oag_mode_e;
    // register numbers within a bank
    localparam logic [2:0] OAG_R_X = 3'h0;
    localparam logic [2:0] OAG_R_A = 3'h1;
    localparam logic [2:0] OAG_R_C = 3'h2;
    localparam logic [2:0] OAG_R_B = 3'h3;
    localparam logic [2:0] OAG_R_E = 3'h4;
    localparam logic [2:0] OAG_R_D = 3'h5;
    localparam logic [2:0] OAG_R_L = 3'h6;
    localparam logic [2:0] OAG_R_H = 3'h7;
    // indirect register codes
    localparam logic [1:0] OAG_I_D = 2'h0;
    localparam logic [1:0] OAG_I_E = 2'h1;
    localparam logic [1:0] OAG_I_EINC = 2'h2;
    // address windows
    localparam logic [7:0] OAG_SADDR_HI_RAM = 8'hfe;
    localparam logic [7:0] OAG_SADDR_HI_SFR = 8'hff;
    localparam logic [7:0] OAG_SADDR_SPLIT = 8'h20;
    localparam logic [7:0] OAG_SFR_HI = 8'hff;
    localparam logic [7:0] OAG_IND_HI = 8'hfe;
    // target spaces
    localparam logic [1:0] OAG_T_NONE = 2'h0;
    localparam logic [1:0] OAG_T_REG = 2'h1;
    localparam logic [1:0] OAG_T_MEM = 2'h2;
    localparam logic [1:0] OAG_T_SFR = 2'h3;
    // reset values
    localparam logic [15:0] OAG_RST_ADDR = 16'h0000;
    localparam logic [1:0] OAG_RST_BANK = 2'h0;
endpackage

// *** core/oag_reg_if.sv ***
`timescale 1ns/1ps
interface oag_reg_if;
    logic [2:0] idx8;
    logic [2:0] reg_sel;
    logic valid;
    modport dec (input idx8, output reg_sel, output valid);
    modport top (output idx8, input reg_sel, input valid);
endinterface

// *** core/oag_class_map.sv ***
`timescale 1ns/1ps
module oag_class_map
    import oag_pkg::*;
(
    input wire logic [2:0] code,
    input wire logic [1:0] cls,
    output logic [2:0] reg_sel,
    output logic valid
);
    // cls 0: full r field, 1: index class, 2: loop-count class
    // ============================================
    // restricted classes
    always_comb begin
        reg_sel = code;
        valid = 1'b1;
        case (cls)
            2'h1: begin
                reg_sel = code[0] ? OAG_R_B : OAG_R_A;
            end
            2'h2: begin
                reg_sel = code[0] ? OAG_R_C : OAG_R_B;
            end
            2'h0: begin
                reg_sel = code;
            end
            default: begin
                valid = 1'b0;
            end
        endcase
    end
endmodule

// *** core/oag_core.sv ***
`timescale 1ns/1ps
module oag_core
    import oag_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic op_valid,
    input wire logic [3:0] op_mode,
    input wire logic [2:0] op_code,
    input wire logic op_bit5,
    input wire logic [7:0] op_byte0,
    input wire logic [7:0] op_byte1,
    input wire logic bank_select_high,
    input wire logic bank_select_low,
    input wire logic [63:0] bank_regs,
    output logic acc_valid,
    output logic [1:0] acc_space,
    output logic [15:0] acc_addr,
    output logic acc_word,
    output logic [1:0] acc_bank,
    output logic [2:0] acc_reg,
    output logic [1:0] acc_pair,
    output logic [15:0] acc_imm,
    output logic acc_bad,
    output logic e_wr,
    output logic [7:0] e_wdata
);
    // ============================================
    // state
    typedef struct packed {
        logic valid;
        logic [1:0] space;
        logic [15:0] addr;
        logic word;
        logic [1:0] bank;
        logic [2:0] rsel;
        logic [1:0] psel;
        logic [15:0] imm;
        logic bad;
        logic ewr;
        logic [7:0] edat;
    } oag_state_s;

    oag_state_s st_ff;
    oag_state_s nxt_st;

    oag_reg_if rif ();
    logic [1:0] cls;
    logic [7:0] rv_a;
    logic [7:0] rv_b;
    logic [7:0] rv_d;
    logic [7:0] rv_e;
    logic [7:0] rv_h;
    logic [7:0] rv_l;
    logic [15:0] imm16;
    logic [15:0] idx_sum;
    logic [7:0] e_inc;

    // ============================================
    // register file view
    assign rv_a = bank_regs[8*OAG_R_A +: 8];
    assign rv_b = bank_regs[8*OAG_R_B +: 8];
    assign rv_d = bank_regs[8*OAG_R_D +: 8];
    assign rv_e = bank_regs[8*OAG_R_E +: 8];
    assign rv_h = bank_regs[8*OAG_R_H +: 8];
    assign rv_l = bank_regs[8*OAG_R_L +: 8];
    assign imm16 = {op_byte1, op_byte0};
    // index register picked by bit 5
    assign idx_sum = 16'(imm16 + {8'h00, (op_bit5 ? rv_b : rv_a)});
    assign e_inc = 8'(rv_e + 8'h01);

    assign rif.idx8 = op_code;
    assign cls = (op_mode == OAG_M_IDXREG) ? 2'h1 :
                 (op_mode == OAG_M_LOOPREG) ? 2'h2 : 2'h0;

    oag_class_map u_map (
        .code(rif.idx8),
        .cls(cls),
        .reg_sel(rif.reg_sel),
        .valid(rif.valid)
    );

    // ============================================
    // decode
    always_comb begin
        nxt_st = st_ff;
        nxt_st.valid = 1'b0;
        nxt_st.ewr = 1'b0;
        if (op_valid) begin
            nxt_st.valid = 1'b1;
            nxt_st.bank = {bank_select_high, bank_select_low};
            nxt_st.space = OAG_T_NONE;
            nxt_st.addr = OAG_RST_ADDR;
            nxt_st.word = 1'b0;
            nxt_st.rsel = 3'h0;
            nxt_st.psel = 2'h0;
            nxt_st.imm = 16'h0000;
            nxt_st.bad = 1'b0;
            nxt_st.edat = rv_e;
            case (op_mode)
                OAG_M_REG8, OAG_M_IDXREG, OAG_M_LOOPREG: begin
                    nxt_st.space = OAG_T_REG;
                    nxt_st.rsel = rif.reg_sel;
                    nxt_st.bad = ~rif.valid;
                end
                OAG_M_REG16: begin
                    nxt_st.space = OAG_T_REG;
                    nxt_st.word = 1'b1;
                    nxt_st.psel = op_code[1:0];
                end
                OAG_M_IMM8: begin
                    nxt_st.imm = {8'h00, op_byte0};
                end
                OAG_M_IMM16: begin
                    nxt_st.imm = imm16;
                    nxt_st.word = 1'b1;
                end
                OAG_M_SADDR, OAG_M_SADDRP: begin
                    nxt_st.space = OAG_T_MEM;
                    nxt_st.addr = {(op_byte0 < OAG_SADDR_SPLIT) ?
                                   OAG_SADDR_HI_SFR : OAG_SADDR_HI_RAM, op_byte0};
                    if (op_mode == OAG_M_SADDRP) begin
                        nxt_st.word = 1'b1;
                        nxt_st.addr[0] = 1'b0;
                    end
                end
                OAG_M_SFR, OAG_M_SFRP: begin
                    nxt_st.space = OAG_T_SFR;
                    nxt_st.addr = {OAG_SFR_HI, op_byte0};
                    nxt_st.word = (op_mode == OAG_M_SFRP);
                    // low sfr codes belong to short direct
                    nxt_st.bad = (op_byte0 < OAG_SADDR_SPLIT);
                    if (op_mode == OAG_M_SFRP) begin
                        nxt_st.addr[0] = 1'b0;
                    end
                end
                OAG_M_IND8: begin
                    nxt_st.space = OAG_T_MEM;
                    nxt_st.addr = {OAG_IND_HI, (op_code[1:0] == OAG_I_D) ? rv_d : rv_e};
                    nxt_st.bad = (op_code[1:0] == 2'h3);
                    // e+ bumps e after the access
                    if (op_code[1:0] == OAG_I_EINC) begin
                        nxt_st.ewr = 1'b1;
                        nxt_st.edat = e_inc;
                    end
                end
                OAG_M_INDHL: begin
                    nxt_st.space = OAG_T_MEM;
                    nxt_st.addr = {rv_h, rv_l};
                end
                OAG_M_INDEX: begin
                    nxt_st.space = OAG_T_MEM;
                    nxt_st.addr = idx_sum;
                end
                default: begin
                    nxt_st.bad = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ============================================
    // outputs, all registered
    // address and strobe leave together one cycle after the request
    assign acc_valid = st_ff.valid;
    assign acc_space = st_ff.space;
    assign acc_addr = st_ff.addr;
    assign acc_word = st_ff.word;
    assign acc_bank = st_ff.bank;
    assign acc_reg = st_ff.rsel;
    assign acc_pair = st_ff.psel;
    assign acc_imm = st_ff.imm;
    assign acc_bad = st_ff.bad;
    // e write-back strobes with the access, so the file applies it after the use
    assign e_wr = st_ff.ewr;
    assign e_wdata = st_ff.edat;

    // ============================================
    // checks
    a_saddr_bit8: assert property (@(posedge clk_sys) disable iff (srst)
        (op_valid && op_mode == OAG_M_SADDR) |=>
        (acc_addr[8] == ($past(op_byte0) < 8'h20)) && acc_addr[15:9] == 7'h7f)
        else $error("short direct bit 8 wrong");
    a_saddrp_even: assert property (@(posedge clk_sys) disable iff (srst)
        (op_valid && op_mode == OAG_M_SADDRP) |=> (!acc_addr[0] && acc_word))
        else $error("word short direct not even");
    a_sfr_page: assert property (@(posedge clk_sys) disable iff (srst)
        (op_valid && op_mode == OAG_M_SFR) |=>
        (acc_addr == {8'hff, $past(op_byte0)}) && acc_space == OAG_T_SFR)
        else $error("sfr address wrong");
    a_sfr_low: assert property (@(posedge clk_sys) disable iff (srst)
        (op_valid && op_mode == OAG_M_SFR && op_byte0 < 8'h20) |=> acc_bad)
        else $error("low sfr code accepted");
    a_ind_high: assert property (@(posedge clk_sys) disable iff (srst)
        (op_valid && op_mode == OAG_M_IND8) |=> acc_addr[15:8] == 8'hfe)
        else $error("indirect high byte wrong");
    a_e_incr: assert property (@(posedge clk_sys) disable iff (srst)
        (op_valid && op_mode == OAG_M_IND8 && op_code[1:0] == 2'h2) |=>
        e_wr && e_wdata == 8'($past(bank_regs[39:32]) + 8'h01))
        else $error("e increment wrong");
    a_index_sum: assert property (@(posedge clk_sys) disable iff (srst)
        (op_valid && op_mode == OAG_M_INDEX) |=> acc_addr == 16'({$past(op_byte1),
        $past(op_byte0)} + {8'h00, ($past(op_bit5) ? $past(bank_regs[31:24]) :
        $past(bank_regs[15:8]))}))
        else $error("indexed address wrong");
    a_bank_hold: assert property (@(posedge clk_sys) disable iff (srst)
        op_valid |=> acc_valid && acc_bank == $past({bank_select_high, bank_select_low}))
        else $error("bank not carried");
    a_class_lim: assert property (@(posedge clk_sys) disable iff (srst)
        (op_valid && op_mode == OAG_M_LOOPREG) |=> (acc_reg == 3'h3 || acc_reg == 3'h2))
        else $error("loop class outside b or c");
    a_no_stray: assert property (@(posedge clk_sys) disable iff (srst)
        !op_valid |=> !acc_valid && !e_wr)
        else $error("access without request");

    // ============================================
    // checks on the remaining operand forms

    a_reg8_code: assert property (@(posedge clk_sys) disable iff (srst)
        (op_valid && op_mode == OAG_M_REG8) |=>
        acc_reg == $past(op_code) && acc_space == OAG_T_REG && !acc_bad)
        else $error("byte register code wrong");

    a_pair_code: assert property (@(posedge clk_sys) disable iff (srst)
        (op_valid && op_mode == OAG_M_REG16) |=>
        acc_pair == $past(op_code[1:0]) && acc_word && acc_space == OAG_T_REG)
        else $error("register pair code wrong");

    a_index_cls: assert property (@(posedge clk_sys) disable iff (srst)
        (op_valid && op_mode == OAG_M_IDXREG) |=>
        (acc_reg == OAG_R_A || acc_reg == OAG_R_B) && !acc_bad)
        else $error("index class outside a or b");

    a_imm_byte: assert property (@(posedge clk_sys) disable iff (srst)
        (op_valid && op_mode == OAG_M_IMM8) |=>
        acc_imm == {8'h00, $past(op_byte0)} && !acc_word)
        else $error("byte immediate wrong");

    a_imm_word: assert property (@(posedge clk_sys) disable iff (srst)
        (op_valid && op_mode == OAG_M_IMM16) |=>
        acc_imm == {$past(op_byte1), $past(op_byte0)} && acc_word)
        else $error("word immediate wrong");

    a_saddr_win: assert property (@(posedge clk_sys) disable iff (srst)
        (op_valid && op_mode == OAG_M_SADDR) |=>
        acc_addr >= 16'hfe20 && acc_addr <= 16'hff1f && acc_space == OAG_T_MEM)
        else $error("short direct outside window");

    a_saddr_low: assert property (@(posedge clk_sys) disable iff (srst)
        (op_valid && op_mode == OAG_M_SADDR) |=>
        acc_addr[7:0] == $past(op_byte0) && !acc_word)
        else $error("short direct low byte wrong");

    a_saddrp_pair: assert property (@(posedge clk_sys) disable iff (srst)
        (op_valid && op_mode == OAG_M_SADDRP) |=>
        acc_addr[15:1] == {(($past(op_byte0) < 8'h20) ? 8'hff : 8'hfe),
        $past(op_byte0[7:1])} && acc_space == OAG_T_MEM)
        else $error("word short direct address wrong");

    a_sfrp_word: assert property (@(posedge clk_sys) disable iff (srst)
        (op_valid && op_mode == OAG_M_SFRP) |=>
        acc_word && acc_addr == {8'hff, $past(op_byte0[7:1]), 1'b0} &&
        acc_space == OAG_T_SFR)
        else $error("word sfr address wrong");

    a_sfr_byte: assert property (@(posedge clk_sys) disable iff (srst)
        (op_valid && op_mode == OAG_M_SFR) |=> !acc_word)
        else $error("byte sfr flagged as word");

    a_ind_low: assert property (@(posedge clk_sys) disable iff (srst)
        (op_valid && op_mode == OAG_M_IND8 && op_code[1:0] == OAG_I_D) |=>
        acc_addr[7:0] == $past(bank_regs[47:40]) && acc_space == OAG_T_MEM && !e_wr)
        else $error("indirect d low byte wrong");

    a_ind_e: assert property (@(posedge clk_sys) disable iff (srst)
        (op_valid && op_mode == OAG_M_IND8 && op_code[1:0] == OAG_I_E) |=>
        acc_addr[7:0] == $past(bank_regs[39:32]) && !e_wr)
        else $error("indirect e low byte wrong");

    a_hl_addr: assert property (@(posedge clk_sys) disable iff (srst)
        (op_valid && op_mode == OAG_M_INDHL) |=>
        acc_addr == $past(bank_regs[63:48]) && acc_space == OAG_T_MEM)
        else $error("indirect hl address wrong");

    a_ind_bad: assert property (@(posedge clk_sys) disable iff (srst)
        (op_valid && op_mode == OAG_M_IND8 && op_code[1:0] == 2'h3) |=> acc_bad && !e_wr)
        else $error("unused indirect code accepted");

    a_index_form: assert property (@(posedge clk_sys) disable iff (srst)
        (op_valid && op_mode == OAG_M_INDEX) |=>
        acc_space == OAG_T_MEM && !acc_word && !acc_bad)
        else $error("indexed access form wrong");

    a_class_space: assert property (@(posedge clk_sys) disable iff (srst)
        (op_valid && (op_mode == OAG_M_IDXREG || op_mode == OAG_M_LOOPREG)) |=>
        acc_space == OAG_T_REG && !acc_word)
        else $error("class register form wrong");

    a_mode_none: assert property (@(posedge clk_sys) disable iff (srst)
        (op_valid && op_mode == OAG_M_NONE) |=> acc_bad && acc_space == OAG_T_NONE)
        else $error("unknown mode not flagged");

    a_out_hold: assert property (@(posedge clk_sys) disable iff (srst)
        !op_valid |=> $stable(acc_addr) && $stable(acc_space) && $stable(acc_bank))
        else $error("outputs moved without request");
endmodule

// *** test/oag_rf_model.sv ***
`timescale 1ns/1ps
// ==========================================
// register file beside the operand address generator
module oag_rf_model
    import oag_pkg::*;
(
    input wire logic clk_sys,
    input wire logic bank_select_high,
    input wire logic bank_select_low,
    input wire logic e_wr,
    input wire logic [7:0] e_wdata,
    output logic [63:0] bank_regs
);
    logic [7:0] rf [4][8];
    // every byte differs per bank, so a wrong bank shows in any address formed from registers
    initial begin
        for (int b = 0; b < 4; b++) begin
            for (int n = 0; n < 8; n++) begin
                rf[b][n] = {1'b1, 3'(n), 2'b00, 2'(b)};
            end
        end
    end
    always_comb begin
        for (int n = 0; n < 8; n++) begin
            bank_regs[n*8 +: 8] = rf[{bank_select_high, bank_select_low}][n];
        end
    end
    always @(posedge clk_sys) begin
        if (e_wr === 1'b1) begin
            rf[{bank_select_high, bank_select_low}][OAG_R_E] <= e_wdata;
        end
    end
endmodule

// *** test/tb_top.sv ***
`timescale 1ns/1ps
module tb_top
    import oag_pkg::*;
;
    typedef struct {
        oag_mode_e mode;
        logic [2:0] code;
        logic b5;
        logic [15:0] ops;
        logic [4:0] m;
        logic [1:0] sp;
        logic [15:0] ad;
        logic w;
        logic [2:0] r;
        logic bd;
    } oag_tb_row_s;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic op_valid = 1'b0;
    logic [3:0] op_mode = 4'h0;
    logic [2:0] op_code = 3'h0;
    logic op_bit5 = 1'b0;
    logic [7:0] op_byte0 = 8'h00;
    logic [7:0] op_byte1 = 8'h00;
    logic bank_select_high = 1'b1;
    logic bank_select_low = 1'b0;
    logic [63:0] bank_regs;
    logic acc_valid, acc_word, acc_bad, e_wr;
    logic [1:0] acc_space, acc_bank, acc_pair;
    logic [2:0] acc_reg;
    logic [15:0] acc_addr, acc_imm;
    logic [7:0] e_wdata;
    int fail_count = 0;
    int tests_run = 0;
    int cycles = 0;
    // mask bits: space, addr and word, reg, pair, imm; rows run in bank 2
    oag_tb_row_s rows [24] = '{
        '{OAG_M_REG8, 3'h6, 1'b0, 16'h0000, 5'h05, OAG_T_REG, 16'h0000, 1'b0, 3'h6, 1'b0},
        '{OAG_M_REG16, 3'h2, 1'b0, 16'h0000, 5'h09, OAG_T_REG, 16'h0000, 1'b0, 3'h2, 1'b0},
        '{OAG_M_IDXREG, 3'h0, 1'b0, 16'h0000, 5'h05, OAG_T_REG, 16'h0000, 1'b0, 3'h1, 1'b0},
        '{OAG_M_IDXREG, 3'h1, 1'b0, 16'h0000, 5'h05, OAG_T_REG, 16'h0000, 1'b0, 3'h3, 1'b0},
        '{OAG_M_LOOPREG, 3'h0, 1'b0, 16'h0000, 5'h05, OAG_T_REG, 16'h0000, 1'b0, 3'h3, 1'b0},
        '{OAG_M_LOOPREG, 3'h1, 1'b0, 16'h0000, 5'h05, OAG_T_REG, 16'h0000, 1'b0, 3'h2, 1'b0},
        '{OAG_M_IMM8, 3'h0, 1'b0, 16'h004d, 5'h10, OAG_T_NONE, 16'h0000, 1'b0, 3'h0, 1'b0},
        '{OAG_M_IMM16, 3'h0, 1'b0, 16'h1234, 5'h10, OAG_T_NONE, 16'h0000, 1'b0, 3'h0, 1'b0},
        '{OAG_M_SADDR, 3'h0, 1'b0, 16'h0020, 5'h03, OAG_T_MEM, 16'hfe20, 1'b0, 3'h0, 1'b0},
        '{OAG_M_SADDR, 3'h0, 1'b0, 16'h00ff, 5'h03, OAG_T_MEM, 16'hfeff, 1'b0, 3'h0, 1'b0},
        '{OAG_M_SADDR, 3'h0, 1'b0, 16'h001f, 5'h03, OAG_T_MEM, 16'hff1f, 1'b0, 3'h0, 1'b0},
        // word short direct given only at even codes
        '{OAG_M_SADDRP, 3'h0, 1'b0, 16'h0040, 5'h03, OAG_T_MEM, 16'hfe40, 1'b1, 3'h0, 1'b0},
        '{OAG_M_SADDRP, 3'h0, 1'b0, 16'h001e, 5'h03, OAG_T_MEM, 16'hff1e, 1'b1, 3'h0, 1'b0},
        '{OAG_M_SFR, 3'h0, 1'b0, 16'h0020, 5'h03, OAG_T_SFR, 16'hff20, 1'b0, 3'h0, 1'b0},
        '{OAG_M_SFR, 3'h0, 1'b0, 16'h00ff, 5'h03, OAG_T_SFR, 16'hffff, 1'b0, 3'h0, 1'b0},
        '{OAG_M_SFR, 3'h0, 1'b0, 16'h001f, 5'h00, OAG_T_NONE, 16'h0000, 1'b0, 3'h0, 1'b1},
        '{OAG_M_SFRP, 3'h0, 1'b0, 16'h0031, 5'h03, OAG_T_SFR, 16'hff30, 1'b1, 3'h0, 1'b0},
        '{OAG_M_IND8, 3'h0, 1'b0, 16'h0000, 5'h03, OAG_T_MEM, 16'hfed2, 1'b0, 3'h0, 1'b0},
        '{OAG_M_IND8, 3'h1, 1'b0, 16'h0000, 5'h03, OAG_T_MEM, 16'hfec2, 1'b0, 3'h0, 1'b0},
        '{OAG_M_INDHL, 3'h0, 1'b0, 16'h0000, 5'h03, OAG_T_MEM, 16'hf2e2, 1'b0, 3'h0, 1'b0},
        '{OAG_M_INDEX, 3'h0, 1'b0, 16'h1f10, 5'h03, OAG_T_MEM, 16'h1fa2, 1'b0, 3'h0, 1'b0},
        '{OAG_M_INDEX, 3'h0, 1'b1, 16'hff80, 5'h03, OAG_T_MEM, 16'h0032, 1'b0, 3'h0, 1'b0},
        '{OAG_M_IND8, 3'h3, 1'b0, 16'h0000, 5'h00, OAG_T_NONE, 16'h0000, 1'b0, 3'h0, 1'b1},
        '{OAG_M_NONE, 3'h0, 1'b0, 16'h0000, 5'h01, OAG_T_NONE, 16'h0000, 1'b0, 3'h0, 1'b1}
    };
    oag_core DUT (.clk_sys(clk_sys), .srst(srst), .op_valid(op_valid), .op_mode(op_mode),
        .op_code(op_code), .op_bit5(op_bit5), .op_byte0(op_byte0), .op_byte1(op_byte1),
        .bank_select_high(bank_select_high), .bank_select_low(bank_select_low),
        .bank_regs(bank_regs), .acc_valid(acc_valid), .acc_space(acc_space),
        .acc_addr(acc_addr), .acc_word(acc_word), .acc_bank(acc_bank), .acc_reg(acc_reg),
        .acc_pair(acc_pair), .acc_imm(acc_imm), .acc_bad(acc_bad), .e_wr(e_wr),
        .e_wdata(e_wdata));
    oag_rf_model rf_model (.clk_sys(clk_sys), .bank_select_high(bank_select_high),
        .bank_select_low(bank_select_low), .e_wr(e_wr), .e_wdata(e_wdata),
        .bank_regs(bank_regs));
    always #10 clk_sys = ~clk_sys;
    // ==========================================
    // tasks
    task automatic summarize();
        if (fail_count == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic cmp(input logic [15:0] g, input logic [15:0] e);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %0t got %h exp %h", $time, g, e);
        end
    endtask
    // leaves op_valid high so a following request lands back to back
    task automatic drive(input oag_mode_e m, input logic [2:0] c, input logic b5,
        input logic [15:0] ops);
        @(negedge clk_sys);
        op_mode = m;
        op_code = c;
        op_bit5 = b5;
        {op_byte1, op_byte0} = ops;
        op_valid = 1'b1;
    endtask
    task automatic req(input oag_mode_e m, input logic [2:0] c, input logic b5,
        input logic [15:0] ops);
        drive(m, c, b5, ops);
        @(negedge clk_sys);
        op_valid = 1'b0;
        cmp(acc_valid, 1'b1);
    endtask
    // hang guard, under a hundred cycles are expected
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 2000) begin
            fail_count++;
            summarize();
        end
    end
    // ==========================================
    // main sequence
    initial begin
        oag_tb_row_s r;
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
        srst = 1'b0;
        cmp(acc_valid, 1'b0);
        cmp(acc_addr, OAG_RST_ADDR);
        cmp(acc_bank, OAG_RST_BANK);
        foreach (rows[i]) begin
            r = rows[i];
            req(r.mode, r.code, r.b5, r.ops);
            cmp(acc_bank, 2'h2);
            cmp(acc_bad, r.bd);
            cmp(e_wr, 1'b0);
            if (r.m[0]) cmp(acc_space, r.sp);
            if (r.m[1]) cmp(acc_addr, r.ad);
            if (r.m[1]) cmp(acc_word, r.w);
            if (r.m[2]) cmp(acc_reg, r.r);
            if (r.m[3]) cmp(acc_pair, r.r[1:0]);
            if (r.m[4]) cmp(acc_imm, r.ops);
            @(negedge clk_sys);
            cmp(acc_valid, 1'b0);
        end
        // e+ in bank 1, then plain e sees the bumped value
        bank_select_high = 1'b0;
        bank_select_low = 1'b1;
        req(OAG_M_IND8, OAG_I_EINC, 1'b0, 16'h0000);
        cmp(acc_addr, 16'hfec1);
        cmp(e_wr, 1'b1);
        cmp(e_wdata, 8'hc2);
        req(OAG_M_IND8, OAG_I_E, 1'b0, 16'h0000);
        cmp(acc_addr, 16'hfec2);
        cmp(acc_bank, 2'h1);
        // back to back requests, each result looked at in its own cycle
        drive(OAG_M_REG8, OAG_R_H, 1'b0, 16'h0000);
        drive(OAG_M_SADDR, 3'h0, 1'b0, 16'h0010);
        cmp(acc_reg, OAG_R_H);
        drive(OAG_M_SFR, 3'h0, 1'b0, 16'h0080);
        cmp(acc_valid, 1'b1);
        cmp(acc_addr, 16'hff10);
        @(negedge clk_sys);
        op_valid = 1'b0;
        cmp(acc_addr, 16'hff80);
        cmp(acc_space, OAG_T_SFR);
        @(negedge clk_sys);
        cmp(acc_valid, 1'b0);
        cmp(acc_addr, 16'hff80);
        // reset in mid-run clears the held outputs, then requests resume
        srst = 1'b1;
        @(negedge clk_sys);
        srst = 1'b0;
        cmp(acc_addr, OAG_RST_ADDR);
        cmp(acc_space, OAG_T_NONE);
        cmp(acc_bank, OAG_RST_BANK);
        req(OAG_M_REG16, 3'h3, 1'b0, 16'h0000);
        cmp(acc_pair, 2'h3);
        cmp(acc_bank, 2'h1);
        summarize();
    end
endmodule
